// ===== logic/fsq_defines.svh
// Register map, field positions, command bytes and timing figures of the flash sequencer.
`ifndef FSQ_DEFINES_SVH
`define FSQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FSQ_REG_CTRL        8'h00
`define FSQ_REG_ADDR        8'h04
`define FSQ_REG_WDATA       8'h08
`define FSQ_REG_STATUS      8'h0C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define FSQ_CTRL_POLL_BIT   4
`define FSQ_ST_BUSY_BIT     0
`define FSQ_ST_DONE_BIT     1
`define FSQ_ST_ERR_BIT      2
`define FSQ_ST_DATA_LSB     8
`define FSQ_RST_BYTE        8'h00
`define FSQ_RST_OP          4'h0

// ----------------------------------------------------------------------------
// Operation codes written to the control register
// ----------------------------------------------------------------------------
`define FSQ_OP_READ         4'h1
`define FSQ_OP_PROG         4'h2
`define FSQ_OP_CHIP         4'h3
`define FSQ_OP_SECT         4'h4
`define FSQ_OP_SECT_ADD     4'h5
`define FSQ_OP_SUSP         4'h6
`define FSQ_OP_RESUME       4'h7
`define FSQ_OP_RESET        4'h8

// ----------------------------------------------------------------------------
// Flash command bytes and unlock addresses
// ----------------------------------------------------------------------------
`define FSQ_UNLOCK1_ADDR    16'h5555
`define FSQ_UNLOCK1_DATA    8'hAA
`define FSQ_UNLOCK2_ADDR    16'h2AAA
`define FSQ_UNLOCK2_DATA    8'h55
`define FSQ_CMD_SETUP       8'h80
`define FSQ_CMD_CHIP        8'h10
`define FSQ_CMD_SECT        8'h30
`define FSQ_CMD_PROG        8'hA0
`define FSQ_CMD_SUSP        8'hB0
`define FSQ_CMD_RESUME      8'h30
`define FSQ_CMD_RESET       8'hF0
`define FSQ_TOGGLE_BIT      6
`define FSQ_FAIL_BIT        5

// ----------------------------------------------------------------------------
// Timing in nanoseconds
// ----------------------------------------------------------------------------
`define FSQ_CLK_PERIOD_NS   20
`define FSQ_T_WP_NS         50
`define FSQ_T_WPH_NS        20
`define FSQ_T_ACC_NS        150
`define FSQ_T_DF_NS         35
`define FSQ_T_RST_NS        5000

`endif

// ===== logic/fsq_pkg.sv
// Types shared by the flash sequencer.
`default_nettype none

package fsq_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_W_SET,
    S_W_LOW,
    S_W_HOLD,
    S_R_SET,
    S_R_ACC,
    S_R_END,
    S_RST_WAIT
  } fsq_state_e;

  typedef logic [3:0] fsq_op_t;
  typedef logic [7:0] fsq_byte_t;
endpackage

`default_nettype wire

// ===== logic/fsq_host.sv
// Host controller that sequences program, erase and status polling of a byte-wide flash.
// How it works
// RQ1 - Chip erase: two unlocks, 80h, two unlocks, 10h.
// RQ2 - Device drops a malformed chip erase sequence.
// RQ3 - Device preprograms cells itself before erasing.
// RQ4 - Reads after sixth write return status bits.
// RQ5 - Device ignores all but reset during chip erase.
// RQ6 - Polling bit low while erasing; toggle bit toggles.
// RQ7 - Error bit set when erase cannot verify.
// RQ8 - Sector erase: unlocks, 80h, unlocks, 30h with sector.
// RQ9 - Further 30h confirms add sectors without unlocks.
// RQ10 - Erase starts after timeout after last confirm.
// RQ11 - Each new confirm restarts the timeout window.
// RQ12 - Erase timer bit low during timeout, high after.
// RQ13 - Non-30h command during timeout aborts sector erase.
// RQ14 - Sector erase accepts only suspend and reset.
// RQ15 - Host resets controller after a flagged failure.
// RQ16 - Program: two unlocks, A0h, then address and data.
// RQ17 - Address on falling strobe, data on rising strobe.
// RQ18 - No commands accepted while a byte programs.
// RQ19 - Programming only clears bits to zero.
// RQ20 - Suspend B0h, any address, only during sector erase.
// RQ21 - Suspend during timeout ends the timeout too.
// RQ22 - Toggle stops when suspended; poll outside erased sectors.
// RQ23 - Unlocks: AAh to 5555h, then 55h to 2AAAh.
// RQ24 - Reset is F0h; array reads after 5us.
// RQ25 - 30h at any address resumes a suspended erase.
// RQ26 - Polling bit inverted while a byte programs.
// RQ27 - Device model timings are scalable parameters.
`default_nettype none
`include "fsq_defines.svh"

module fsq_host #(
  parameter int AW = 19
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RESETN,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output var logic  [AW-1:0]     O_FL_ADDR,
  output var fsq_pkg::fsq_byte_t O_FL_DQ,
  output var logic               O_FL_DQ_OEN,
  input  wire fsq_pkg::fsq_byte_t I_FL_DQ,
  output var logic               O_FL_CE_N,
  output var logic               O_FL_WE_N,
  output var logic               O_FL_OE_N
);
  import fsq_pkg::*;

  // --------------------------------------------------------------------------
  // Cycle counts
  // --------------------------------------------------------------------------
  localparam int CLK  = `FSQ_CLK_PERIOD_NS;
  localparam logic [7:0] WP_CYC  = 8'((`FSQ_T_WP_NS + CLK - 1) / CLK);
  localparam logic [7:0] WPH_CYC = 8'((`FSQ_T_WPH_NS + CLK - 1) / CLK);
  localparam logic [7:0] ACC_CYC = 8'((`FSQ_T_ACC_NS + CLK - 1) / CLK);
  localparam logic [7:0] DF_CYC  = 8'((`FSQ_T_DF_NS + CLK - 1) / CLK);
  localparam logic [7:0] RST_CYC = 8'((`FSQ_T_RST_NS + CLK - 1) / CLK);

  // --------------------------------------------------------------------------
  // Command step tables
  // --------------------------------------------------------------------------
  function automatic logic [2:0] step_count(input fsq_op_t op);
    case (op)
      `FSQ_OP_PROG: step_count = 3'd4;
      `FSQ_OP_CHIP,
      `FSQ_OP_SECT: step_count = 3'd6;
      default:      step_count = 3'd1;
    endcase
  endfunction

  // Returns the address and byte of write number idx of the given operation.
  function automatic logic [AW+7:0] step_word(input fsq_op_t op, input logic [2:0] idx,
                                             input logic [AW-1:0] a, input fsq_byte_t d);
    logic [AW-1:0] u1;
    logic [AW-1:0] u2;
    u1 = AW'(`FSQ_UNLOCK1_ADDR);
    u2 = AW'(`FSQ_UNLOCK2_ADDR);
    step_word = {a, `FSQ_CMD_RESET};
    if (op == `FSQ_OP_PROG) begin
      case (idx)
        3'd0:    step_word = {u1, `FSQ_UNLOCK1_DATA}; // RQ23
        3'd1:    step_word = {u2, `FSQ_UNLOCK2_DATA}; // RQ23
        3'd2:    step_word = {u1, `FSQ_CMD_PROG}; // RQ16
        default: step_word = {a, d}; // RQ16
      endcase
    end else if (op == `FSQ_OP_CHIP || op == `FSQ_OP_SECT) begin
      case (idx)
        3'd0, 3'd3: step_word = {u1, `FSQ_UNLOCK1_DATA}; // RQ23
        3'd1, 3'd4: step_word = {u2, `FSQ_UNLOCK2_DATA}; // RQ23
        3'd2:       step_word = {u1, `FSQ_CMD_SETUP}; // RQ1
        default: begin
          if (op == `FSQ_OP_CHIP) begin
            step_word = {u1, `FSQ_CMD_CHIP}; // RQ1
          end else begin
            step_word = {a, `FSQ_CMD_SECT}; // RQ8
          end
        end
      endcase
    end else begin
      case (op)
        `FSQ_OP_SECT_ADD: step_word = {a, `FSQ_CMD_SECT}; // RQ9
        `FSQ_OP_SUSP:     step_word = {a, `FSQ_CMD_SUSP}; // RQ20
        `FSQ_OP_RESUME:   step_word = {a, `FSQ_CMD_RESUME}; // RQ25
        default:          step_word = {a, `FSQ_CMD_RESET}; // RQ24
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fsq_state_e    state_q, state_d;
  fsq_op_t       op_q, op_d;
  logic          poll_q, poll_d;
  logic [2:0]    idx_q, idx_d;
  logic [7:0]    cnt_q, cnt_d;
  logic [AW-1:0] addr_q, addr_d;
  fsq_byte_t     wdata_q, wdata_d;
  fsq_byte_t     rdata_q, rdata_d;
  logic          have_prev_q, have_prev_d;
  logic          final_q, final_d;
  logic          more_q, more_d;
  logic          done_q, done_d;
  logic          err_q, err_d;
  logic [AW-1:0] fl_addr_q, fl_addr_d;
  fsq_byte_t     fl_dq_q, fl_dq_d;
  logic          dq_oen_q, dq_oen_d;
  logic          ce_n_q, ce_n_d;
  logic          we_n_q, we_n_d;
  logic          oe_n_q, oe_n_d;
  logic          wr_en;
  logic          busy;
  logic          mapped;
  logic [AW+7:0] step;

  assign wr_en  = PSEL && PENABLE && PWRITE;
  assign busy   = (state_q != S_IDLE);
  assign step   = step_word(op_q, idx_q, addr_q, wdata_q);
  assign mapped = (PADDR == `FSQ_REG_CTRL) || (PADDR == `FSQ_REG_ADDR) ||
                  (PADDR == `FSQ_REG_WDATA) || (PADDR == `FSQ_REG_STATUS);

  // --------------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped offsets
  // --------------------------------------------------------------------------
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  always_comb begin
    PRDATA = 32'h0000_0000;
    case (PADDR)
      `FSQ_REG_CTRL:   PRDATA = {27'h0000000, poll_q, op_q};
      `FSQ_REG_ADDR:   PRDATA = 32'(addr_q);
      `FSQ_REG_WDATA:  PRDATA = {24'h000000, wdata_q};
      `FSQ_REG_STATUS: PRDATA = {16'h0000, rdata_q, 5'h00, err_q, done_q, busy};
      default:         PRDATA = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    op_d        = op_q;
    poll_d      = poll_q;
    idx_d       = idx_q;
    cnt_d       = cnt_q;
    addr_d      = addr_q;
    wdata_d     = wdata_q;
    rdata_d     = rdata_q;
    have_prev_d = have_prev_q;
    final_d     = final_q;
    more_d      = more_q;
    done_d      = done_q;
    err_d       = err_q;
    fl_addr_d   = fl_addr_q;
    fl_dq_d     = fl_dq_q;
    dq_oen_d    = dq_oen_q;
    ce_n_d      = ce_n_q;
    we_n_d      = we_n_q;
    oe_n_d      = oe_n_q;
    // Address and data may be rewritten only while idle, so a running sequence never sees them move.
    if (wr_en && !busy && PADDR == `FSQ_REG_ADDR) begin
      addr_d = PWDATA[AW-1:0];
    end
    if (wr_en && !busy && PADDR == `FSQ_REG_WDATA) begin
      wdata_d = PWDATA[7:0];
    end
    case (state_q)
      S_IDLE: begin
        if (wr_en && PADDR == `FSQ_REG_CTRL) begin
          op_d        = PWDATA[3:0];
          poll_d      = PWDATA[`FSQ_CTRL_POLL_BIT];
          idx_d       = 3'd0;
          done_d      = 1'b0;
          err_d       = 1'b0;
          have_prev_d = 1'b0;
          final_d     = 1'b0;
          state_d     = (PWDATA[3:0] == `FSQ_OP_READ) ? S_R_SET : S_W_SET;
        end
      end
      S_W_SET: begin
        // Strobes fall together; the device takes the address on this edge and the byte on the rise.
        fl_addr_d = step[AW+7:8]; // RQ17
        fl_dq_d   = step[7:0];
        dq_oen_d  = 1'b0;
        ce_n_d    = 1'b0;
        we_n_d    = 1'b0;
        cnt_d     = WP_CYC - 8'd1;
        state_d   = S_W_LOW;
      end
      S_W_LOW: begin
        if (cnt_q == 8'd0) begin
          we_n_d  = 1'b1; // RQ17
          ce_n_d  = 1'b1;
          cnt_d   = WPH_CYC - 8'd1;
          state_d = S_W_HOLD;
        end else begin
          cnt_d = cnt_q - 8'd1;
        end
      end
      S_W_HOLD: begin
        if (cnt_q != 8'd0) begin
          cnt_d = cnt_q - 8'd1;
        end else begin
          dq_oen_d = 1'b1;
          idx_d    = idx_q + 3'd1;
          if (idx_q + 3'd1 < step_count(op_q)) begin
            state_d = S_W_SET;
          end else if (op_q == `FSQ_OP_RESET) begin
            cnt_d   = RST_CYC - 8'd1; // RQ24
            state_d = S_RST_WAIT;
          end else if (poll_q) begin
            state_d = S_R_SET; // RQ4 RQ18
          end else begin
            done_d  = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      S_R_SET: begin
        // Polling reads go to the programmed byte or a sector chosen by software.
        fl_addr_d = addr_q; // RQ22
        ce_n_d    = 1'b0;
        oe_n_d    = 1'b0;
        cnt_d     = ACC_CYC - 8'd1;
        state_d   = S_R_ACC;
      end
      S_R_ACC: begin
        if (cnt_q != 8'd0) begin
          cnt_d = cnt_q - 8'd1;
        end else begin
          rdata_d     = I_FL_DQ;
          have_prev_d = 1'b1;
          ce_n_d      = 1'b1;
          oe_n_d      = 1'b1;
          cnt_d       = DF_CYC - 8'd1;
          state_d     = S_R_END;
          more_d      = 1'b1;
          if (op_q == `FSQ_OP_READ) begin
            more_d = 1'b0;
          end else if (have_prev_q &&
                       I_FL_DQ[`FSQ_TOGGLE_BIT] == rdata_q[`FSQ_TOGGLE_BIT]) begin
            more_d = 1'b0; // RQ6
          end else if (have_prev_q && final_q) begin
            err_d  = 1'b1; // RQ7
            more_d = 1'b0;
          end else if (have_prev_q && I_FL_DQ[`FSQ_FAIL_BIT]) begin
            final_d = 1'b1; // RQ7
          end
        end
      end
      S_R_END: begin
        // The data bus needs its float time before the next drive.
        if (cnt_q != 8'd0) begin
          cnt_d = cnt_q - 8'd1;
        end else if (more_q) begin
          state_d = S_R_SET;
        end else if (err_q) begin
          // A failed operation leaves the device's controller stuck until reset.
          op_d    = `FSQ_OP_RESET; // RQ15
          idx_d   = 3'd0;
          state_d = S_W_SET;
        end else begin
          done_d  = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_RST_WAIT: begin
        if (cnt_q != 8'd0) begin
          cnt_d = cnt_q - 8'd1;
        end else begin
          done_d  = 1'b1; // RQ24
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q     <= S_IDLE;
      op_q        <= `FSQ_RST_OP;
      poll_q      <= 1'b0;
      idx_q       <= 3'd0;
      cnt_q       <= 8'h00;
      addr_q      <= '0;
      wdata_q     <= `FSQ_RST_BYTE;
      rdata_q     <= `FSQ_RST_BYTE;
      have_prev_q <= 1'b0;
      final_q     <= 1'b0;
      more_q      <= 1'b0;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
      fl_addr_q   <= '0;
      fl_dq_q     <= `FSQ_RST_BYTE;
      dq_oen_q    <= 1'b1;
      ce_n_q      <= 1'b1;
      we_n_q      <= 1'b1;
      oe_n_q      <= 1'b1;
    end else begin
      state_q     <= state_d;
      op_q        <= op_d;
      poll_q      <= poll_d;
      idx_q       <= idx_d;
      cnt_q       <= cnt_d;
      addr_q      <= addr_d;
      wdata_q     <= wdata_d;
      rdata_q     <= rdata_d;
      have_prev_q <= have_prev_d;
      final_q     <= final_d;
      more_q      <= more_d;
      done_q      <= done_d;
      err_q       <= err_d;
      fl_addr_q   <= fl_addr_d;
      fl_dq_q     <= fl_dq_d;
      dq_oen_q    <= dq_oen_d;
      ce_n_q      <= ce_n_d;
      we_n_q      <= we_n_d;
      oe_n_q      <= oe_n_d;
    end
  end

  assign O_FL_ADDR   = fl_addr_q;
  assign O_FL_DQ     = fl_dq_q;
  assign O_FL_DQ_OEN = dq_oen_q;
  assign O_FL_CE_N   = ce_n_q;
  assign O_FL_WE_N   = we_n_q;
  assign O_FL_OE_N   = oe_n_q;

endmodule

`default_nettype wire

// ===== tb/fsq_host_asserts.sv
// Concurrent checks on the register bus and flash strobes of the flash sequencer.
`default_nettype none
`include "fsq_defines.svh"
module fsq_host_asserts #(
  parameter int AW = 19
) (
  input wire logic               I_REF_CLK,
  input wire logic               I_RESETN,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic [7:0]         PADDR,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic [AW-1:0]      O_FL_ADDR,
  input wire fsq_pkg::fsq_byte_t O_FL_DQ,
  input wire logic               O_FL_DQ_OEN,
  input wire logic               O_FL_CE_N,
  input wire logic               O_FL_WE_N,
  input wire logic               O_FL_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  import fsq_pkg::*;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  logic acc;
  logic mapped;
  assign acc = PSEL && PENABLE;
  assign mapped = PADDR inside {`FSQ_REG_CTRL, `FSQ_REG_ADDR, `FSQ_REG_WDATA, `FSQ_REG_STATUS};
  apb_ready_a:
    assert property (acc |-> PREADY) else $error("access phase without ready");
  unmapped_err_a:
    assert property (acc && !mapped |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
  mapped_ok_a:
    assert property (acc && mapped |-> !PSLVERR) else $error("mapped access refused");
  we_pulse_a:
    assert property ($fell(O_FL_WE_N) |-> !O_FL_WE_N [*3] ##1 O_FL_WE_N) else $error("write pulse length wrong");
  wr_stable_a:
    assert property (!O_FL_WE_N && !$past(O_FL_WE_N) |-> $stable(O_FL_ADDR) && $stable(O_FL_DQ))
      else $error("address or data moved in write pulse");
  we_frame_a:
    assert property (!O_FL_WE_N |-> !O_FL_CE_N && O_FL_OE_N && !O_FL_DQ_OEN) else $error("write pulse framing wrong");
  read_len_a:
    assert property ($fell(O_FL_OE_N) |-> (!O_FL_OE_N && O_FL_DQ_OEN && O_FL_WE_N) [*8] ##1 O_FL_OE_N)
      else $error("read strobe length wrong");
  float_gap_a:
    assert property ($rose(O_FL_OE_N) |-> O_FL_DQ_OEN [*2]) else $error("bus driven too soon after read");
endmodule
bind fsq_host fsq_host_asserts #(.AW(AW)) u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .O_FL_ADDR(O_FL_ADDR), .O_FL_DQ(O_FL_DQ),
  .O_FL_DQ_OEN(O_FL_DQ_OEN), .O_FL_CE_N(O_FL_CE_N), .O_FL_WE_N(O_FL_WE_N), .O_FL_OE_N(O_FL_OE_N));
`default_nettype wire

// ===== tb/fsq_flash_model.sv
// Behavioural byte-wide flash device on the far side of the sequencer.
`default_nettype none
module fsq_flash_model #(
  parameter int T_PROG  = 2000,
  parameter int T_ERASE = 20000,
  parameter int T_TOUT  = 10000
) (
  input  wire logic [18:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_fail,
  output logic      [7:0]  o_dq = 8'h00,
  output logic             o_drive = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Timers are settled lazily at each rising write strobe and falling read strobe, so no free-running clock is needed.
  logic [7:0]  mem [int];
  logic [7:0]  sel = 8'h00;
  logic [7:0]  pdat;
  logic [18:0] wa;
  logic [18:0] pa;
  logic        tog = 1'b0;
  logic        err = 1'b0;
  logic        chip = 1'b0;
  int          step = 0;
  int          mode = 0;
  longint      t_end;
  longint      t_left;
  function automatic logic [7:0] rd(input logic [18:0] ad);
    return mem.exists(ad) ? mem[ad] : 8'hFF;
  endfunction
  task automatic settle();
    if (mode == 3 && $time >= t_end) begin
      mode = 2;
      t_end = t_end + T_ERASE;
    end
    if (mode == 1 && $time >= t_end) begin
      mem[pa] = rd(pa) & pdat;
      mode = 0;
    end
    if (mode == 2 && $time >= t_end && !err) begin
      if (i_fail) err = 1'b1;
      else begin
        foreach (mem[k]) if (sel[k[18:16]]) mem[k] = 8'hFF;
        mode = 0;
      end
    end
  endtask
  task automatic cmd(input logic [18:0] ad, input logic [7:0] dv);
    if (mode == 1) return;
    if (dv == 8'hF0) begin
      mode = 0;
      step = 0;
      err = 1'b0;
      return;
    end
    if (mode == 2) begin
      if (dv == 8'hB0 && !chip) begin
        t_left = t_end - $time;
        mode = 4;
      end
    end else if (mode == 3) begin
      if (dv == 8'h30) begin
        sel[ad[18:16]] = 1'b1;
        t_end = $time + T_TOUT;
      end else if (dv == 8'hB0) begin
        t_left = T_ERASE;
        mode = 4;
      end else mode = 0;
    end else if (mode == 4) begin
      if (dv == 8'h30) begin
        mode = 2;
        t_end = $time + t_left;
      end
    end else case (step)
      0, 3: step = (dv == 8'hAA && ad == 19'h05555) ? step + 1 : 0;
      1, 4: step = (dv == 8'h55 && ad == 19'h02AAA) ? step + 1 : 0;
      2: step = dv == 8'hA0 ? 6 : (dv == 8'h80 && ad == 19'h05555) ? 3 : 0;
      5: begin
        step = 0;
        chip = dv == 8'h10 && ad == 19'h05555;
        sel = chip ? 8'hFF : 8'h00;
        if (chip || dv == 8'h30) begin
          sel[ad[18:16]] = 1'b1;
          mode = chip ? 2 : 3;
          t_end = $time + (chip ? T_ERASE : T_TOUT);
        end
      end
      default: begin
        pa = ad;
        pdat = dv;
        mode = 1;
        step = 0;
        t_end = $time + T_PROG;
      end
    endcase
  endtask
  // The host moves address and strobe on one edge, so the address is taken just after the fall.
  always @(negedge i_we_n) #1 wa = i_addr;
  always @(posedge i_we_n) begin
    settle();
    cmd(wa, i_dq);
  end
  always @(negedge i_oe_n) begin
    #1;
    settle();
    if (mode inside {1, 2, 3}) begin
      tog = ~tog;
      o_dq = {mode == 1 ? ~pdat[7] : 1'b0, tog, err, 1'b0, mode != 3, 3'b000};
    end else o_dq = rd(i_addr);
    o_drive = 1'b1;
  end
  always @(posedge i_oe_n) o_drive = 1'b0;
endmodule
`default_nettype wire

// ===== tb/fsq_host_tb.sv
// Self-checking bench for the flash sequencer driving a behavioural flash.
`default_nettype none
`include "fsq_defines.svh"
module fsq_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        fail_inj = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, st;
  logic        pready, pslverr, oen, ce_n, we_n, oe_n, m_drv, e;
  logic [18:0] fa, a, a3;
  logic [7:0]  hdq, mdq, fdq, d;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  shadow [int];
  int          fail_count = 0;
  int          comparisons = 0;
  always #10 clk = ~clk;
  // A released bus shows the inverse of its value one clock earlier, so it alternates each cycle with the last driven byte.
  always @(posedge clk) last_q <= fdq;
  assign fdq = !oen ? hdq : m_drv ? mdq : ~last_q;
  fsq_host #(.AW(19)) dut_u (
    .I_REF_CLK(clk), .I_RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .O_FL_ADDR(fa), .O_FL_DQ(hdq),
    .O_FL_DQ_OEN(oen), .I_FL_DQ(fdq), .O_FL_CE_N(ce_n), .O_FL_WE_N(we_n), .O_FL_OE_N(oe_n));
  fsq_flash_model flash_u (.i_addr(fa), .i_dq(fdq), .i_we_n(we_n), .i_oe_n(oe_n), .i_fail(fail_inj),
    .o_dq(mdq), .o_drive(m_drv));
  function automatic logic [7:0] exp_rd(input logic [18:0] ad);
    return shadow.exists(ad) ? shadow[ad] : 8'hFF;
  endfunction
  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, got);
      fail_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled access.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    st = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [3:0] c, input logic [18:0] ad, input logic [7:0] dv, input logic poll);
    int n = 0;
    apb(1'b1, `FSQ_REG_ADDR, {13'h0, ad});
    apb(1'b1, `FSQ_REG_WDATA, {24'h0, dv});
    apb(1'b1, `FSQ_REG_CTRL, {27'h0, poll, c});
    do begin
      apb(1'b0, `FSQ_REG_STATUS, 32'h0);
      n++;
    end while (st[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic rd_chk(input logic [18:0] ad);
    op(`FSQ_OP_READ, ad, 8'h00, 1'b0);
    chk("read byte and flags", {21'h0, exp_rd(ad), 3'b010}, {21'h0, st[15:8], st[2:0]});
  endtask
  task automatic erase_shadow(input logic [7:0] m);
    foreach (shadow[k]) if (m[k[18:16]]) shadow[k] = 8'hFF;
  endtask
  // A plain read samples the flash once, so the bench repeats it at sector 0 until the toggle bit settles.
  task automatic wait_idle();
    logic [7:0] prev;
    int         n = 0;
    do begin
      prev = st[15:8];
      op(`FSQ_OP_READ, 19'h0, 8'h00, 1'b0);
      n++;
    end while ((n < 2 || st[14] !== prev[6]) && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1_500_000;
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h4E4F));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, `FSQ_REG_STATUS, 32'h0);
    chk("status after reset", 32'h0, st);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h1, {st[30:0], e});
    for (int i = 0; i < 6; i++) begin
      if (i % 2 == 0) a = {3'(1 + i / 2), 16'($urandom)};
      d = (i == 0) ? 8'h00 : 8'($urandom);
      op(`FSQ_OP_PROG, a, d, 1'b1);
      shadow[a] = exp_rd(a) & d;
      rd_chk(a);
    end
    a3 = a;
    op(`FSQ_OP_SECT, {3'd1, 16'h0}, 8'h00, 1'b0);
    op(`FSQ_OP_SECT_ADD, {3'd2, 16'h0}, 8'h00, 1'b0);
    op(`FSQ_OP_READ, 19'h0, 8'h00, 1'b0);
    chk("erase timer bit in window", 32'h0, {31'h0, st[11]});
    repeat (600) @(posedge clk);
    op(`FSQ_OP_READ, 19'h0, 8'h00, 1'b0);
    chk("poll and timer bits erasing", 32'h1, {30'h0, st[15], st[11]});
    wait_idle();
    erase_shadow(8'h06);
    foreach (shadow[k]) rd_chk(k[18:0]);
    op(`FSQ_OP_SECT, a3, 8'h00, 1'b0);
    op(`FSQ_OP_RESET, 19'h0, 8'h00, 1'b0);
    repeat (2000) @(posedge clk);
    rd_chk(a3);
    a = 19'h41234;
    op(`FSQ_OP_PROG, a, 8'h3C, 1'b1);
    shadow[a] = 8'h3C;
    op(`FSQ_OP_SECT, a, 8'h00, 1'b0);
    op(`FSQ_OP_SUSP, 19'h0, 8'h00, 1'b0);
    wait_idle();
    rd_chk(a);
    op(`FSQ_OP_RESUME, 19'h0, 8'h00, 1'b0);
    wait_idle();
    erase_shadow(8'h10);
    rd_chk(a);
    fail_inj <= 1'b1;
    op(`FSQ_OP_CHIP, 19'h0, 8'h00, 1'b1);
    chk("failed erase flag", 32'h1, {31'h0, st[2]});
    fail_inj <= 1'b0;
    rd_chk(a3);
    op(`FSQ_OP_CHIP, 19'h0, 8'h00, 1'b0);
    op(`FSQ_OP_SUSP, 19'h0, 8'h00, 1'b0);
    wait_idle();
    erase_shadow(8'hFF);
    rd_chk(a3);
    end_of_test();
  end
endmodule
`default_nettype wire
